// ### common/dpmb_pkg.sv
// Shared constants and types for the dual-port mailbox and reset controller
package dpmb_pkg;

   // ----------------------------------------
   // Sizes and reset values
   // ----------------------------------------
   localparam int ADDR_W = 21;
   localparam logic [ADDR_W-1:0] CNT_RST_VAL = 21'h000000;
   localparam logic [ADDR_W-1:0] MASK_RST_VAL = 21'h1fffff;
   localparam logic [ADDR_W-1:0] BUSY_RST_VAL = 21'h000000;

   // ----------------------------------------
   // Increment step by low mask bits
   // ----------------------------------------
   localparam logic [1:0] STEP_SEL_ONE = 2'h3;
   localparam logic [1:0] STEP_SEL_TWO = 2'h2;
   localparam logic [1:0] STEP_SEL_FOUR = 2'h0;

   // ----------------------------------------
   // Start-up timing
   // ----------------------------------------
   localparam int READY_CAL_CYC = 1024;
   localparam int READY_NOCAL_CYC = 160;
   localparam int OPER_NOCAL_CYC = 5;
   localparam int READY_CNT_W = 11;

   // One port's memory access as seen by this block
   typedef struct packed {
      logic ce;
      logic rd;
      logic wr;
      logic [3:0] be;
      logic [ADDR_W-1:0] addr;
   } dpmb_acc_t;

   // Counter control
   typedef struct packed {
      logic cnt_rst;
      logic mask_rst;
      logic cnt_load;
      logic mask_load;
      logic incr;
      logic [ADDR_W-1:0] addr;
   } dpmb_cnt_cmd_t;

   typedef enum logic [1:0] {ST_RESET, ST_CAL, ST_READY} dpmb_start_t;

endpackage : dpmb_pkg

// ### core/dpmb_counter.sv
// Burst address counter with mask and mirror for one port
`timescale 1ns/1ns
`default_nettype none
module dpmb_counter
   import dpmb_pkg::*;
#(
   parameter int AW = ADDR_W
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire dpmb_cnt_cmd_t cmd,
   output logic [AW-1:0] cnt_ff,
   output logic [AW-1:0] mask_ff,
   output logic [AW-1:0] mirror_ff
);

   logic [AW-1:0] nxt_cnt;
   logic [AW-1:0] nxt_mask;
   logic [AW-1:0] nxt_mirror;
   logic [AW-1:0] step;
   logic [AW-1:0] sum;

   always_comb
   begin
      case (mask_ff[1:0])
         STEP_SEL_ONE: step = AW'(1);
         STEP_SEL_TWO: step = AW'(2);
         STEP_SEL_FOUR: step = AW'(4);
         default: step = AW'(1);
      endcase
      // Carry ripples through masked bits by forcing them to ones
      sum = (cnt_ff | ~mask_ff) + step;
      nxt_cnt = cnt_ff;
      nxt_mask = mask_ff;
      nxt_mirror = mirror_ff;
      if (cmd.cnt_rst)
      begin
         nxt_cnt = cnt_ff & ~mask_ff;
         nxt_mirror = mirror_ff & ~mask_ff;
      end
      else if (cmd.mask_rst)
         nxt_mask = MASK_RST_VAL[AW-1:0];
      else if (cmd.cnt_load)
      begin
         nxt_cnt = cmd.addr[AW-1:0];
         nxt_mirror = cmd.addr[AW-1:0];
      end
      else if (cmd.mask_load)
         nxt_mask = cmd.addr[AW-1:0];
      else if (cmd.incr)
      begin
         // Wrap back to the loaded base when unmasked bits are all ones
         if ((cnt_ff & mask_ff) == mask_ff)
            nxt_cnt = mirror_ff;
         else
            nxt_cnt = (cnt_ff & ~mask_ff) | (sum & mask_ff);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_ff <= CNT_RST_VAL[AW-1:0];
         mask_ff <= MASK_RST_VAL[AW-1:0];
         mirror_ff <= CNT_RST_VAL[AW-1:0];
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         mask_ff <= nxt_mask;
         mirror_ff <= nxt_mirror;
      end
   end

endmodule : dpmb_counter
`default_nettype wire

// ### core/dpmb_port_ctrl.sv
// Mailbox flags, counters and reset sequencing for both memory ports
//
// Notes on behaviour
// - Mask low bits 00: each increment advances the counter by four.
// - Mask low bits 11 step one, 10 step two.
// - Only counter bits with mask bit one change on increment.
// - Top address is the right mailbox, one below it the left.
// - Writing the other port's mailbox drives that port's interrupt low.
// - Interrupt stays set until its mailbox is read by its owner.
// - Owner's read clears interrupt one cycle later, regardless of output enable.
// - Right port read of the top address clears right interrupt next cycle.
// - Mailbox set or clear needs chip enable and at least one byte enable.
// - Master reset is asynchronous; outside holds it for the minimum time.
// - Reset drops ready, zeroes counters, mirrors, busy; mask goes all ones.
// - Reset deasserts mailbox, busy and counter wrap interrupts.
// - Release starts calibration; ready asserts within 1024 cycles.
// - Calibration off: operational in five cycles, ready within 160.
`timescale 1ns/1ns
`default_nettype none
module dpmb_port_ctrl
   import dpmb_pkg::*;
#(
   parameter int AW = ADDR_W
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire dpmb_acc_t acc_left,
   input wire dpmb_acc_t acc_right,
   input wire dpmb_cnt_cmd_t cnt_cmd_left,
   input wire dpmb_cnt_cmd_t cnt_cmd_right,
   input wire logic [AW-1:0] busy_addr_in,
   input wire logic busy_event,
   input wire logic impedance_match,
   input wire logic low_speed_select,
   input wire logic echo_clock_enable,
   input wire logic latency_select,
   input wire logic io_standard_select,
   output logic int_left_n_ff,
   output logic int_right_n_ff,
   output logic busy_n_ff,
   output logic [AW-1:0] busy_addr_ff,
   output logic counter_wrap_irq_n_ff,
   output logic ready_n_ff,
   output logic operational_ff,
   output logic [AW-1:0] cnt_left,
   output logic [AW-1:0] cnt_right,
   output logic [AW-1:0] mask_left,
   output logic [AW-1:0] mask_right
);

   // ----------------------------------------
   // Mailbox decode
   // ----------------------------------------
   localparam logic [AW-1:0] MBOX_RIGHT = {AW{1'b1}};
   localparam logic [AW-1:0] MBOX_LEFT = {{(AW-1){1'b1}}, 1'b0};

   logic l_valid;
   logic r_valid;
   logic set_right;
   logic clr_right;
   logic set_left;
   logic clr_left;
   logic nxt_int_left_n;
   logic nxt_int_right_n;

   always_comb
   begin
      l_valid = acc_left.ce && (|acc_left.be);
      r_valid = acc_right.ce && (|acc_right.be);
      set_right = l_valid && acc_left.wr && acc_left.addr[AW-1:0] == MBOX_RIGHT;
      set_left = r_valid && acc_right.wr && acc_right.addr[AW-1:0] == MBOX_LEFT;
      // Output enable is not an input here on purpose
      clr_right = r_valid && acc_right.rd && acc_right.addr[AW-1:0] == MBOX_RIGHT;
      clr_left = l_valid && acc_left.rd && acc_left.addr[AW-1:0] == MBOX_LEFT;
      // Set wins over a clear in the same cycle so no message is lost
      nxt_int_right_n = int_right_n_ff;
      if (set_right)
         nxt_int_right_n = 1'b0;
      else if (clr_right)
         nxt_int_right_n = 1'b1;
      nxt_int_left_n = int_left_n_ff;
      if (set_left)
         nxt_int_left_n = 1'b0;
      else if (clr_left)
         nxt_int_left_n = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         int_left_n_ff <= 1'b1;
         int_right_n_ff <= 1'b1;
      end
      else
      begin
         int_left_n_ff <= nxt_int_left_n;
         int_right_n_ff <= nxt_int_right_n;
      end
   end

   // ----------------------------------------
   // Burst counters
   // ----------------------------------------
   logic [AW-1:0] mirror_left;
   logic [AW-1:0] mirror_right;

   dpmb_counter #(.AW(AW)) u_cnt_left (
      .clk(clk),
      .rst_n(rst_n),
      .cmd(cnt_cmd_left),
      .cnt_ff(cnt_left),
      .mask_ff(mask_left),
      .mirror_ff(mirror_left)
   );

   dpmb_counter #(.AW(AW)) u_cnt_right (
      .clk(clk),
      .rst_n(rst_n),
      .cmd(cnt_cmd_right),
      .cnt_ff(cnt_right),
      .mask_ff(mask_right),
      .mirror_ff(mirror_right)
   );

   // ----------------------------------------
   // Counter wrap flag and busy capture
   // ----------------------------------------
   logic nxt_wrap_n;
   logic nxt_busy_n;
   logic [AW-1:0] nxt_busy_addr;
   logic left_near;
   logic right_near;

   always_comb
   begin
      // One increment away from all-ones unmasked bits (step one case)
      left_near = ((cnt_left | ~mask_left) + AW'(1)) == {AW{1'b1}};
      right_near = ((cnt_right | ~mask_right) + AW'(1)) == {AW{1'b1}};
      nxt_wrap_n = 1'b1;
      if (cnt_cmd_left.incr && left_near && !cnt_cmd_left.cnt_rst && !cnt_cmd_left.cnt_load)
         nxt_wrap_n = 1'b0;
      if (cnt_cmd_right.incr && right_near && !cnt_cmd_right.cnt_rst
          && !cnt_cmd_right.cnt_load)
         nxt_wrap_n = 1'b0;
      nxt_busy_n = !busy_event;
      nxt_busy_addr = busy_addr_ff;
      if (busy_event && busy_n_ff)
         nxt_busy_addr = busy_addr_in; // First colliding address is kept
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         counter_wrap_irq_n_ff <= 1'b1;
         busy_n_ff <= 1'b1;
         busy_addr_ff <= BUSY_RST_VAL[AW-1:0];
      end
      else
      begin
         counter_wrap_irq_n_ff <= nxt_wrap_n;
         busy_n_ff <= nxt_busy_n;
         busy_addr_ff <= nxt_busy_addr;
      end
   end

   // ----------------------------------------
   // Start-up and ready
   // ----------------------------------------
   logic cal_disable_ff;
   logic ready_int;
   logic oper_int;
   logic [3:0] sel_seen_ff;
   logic [3:0] nxt_sel_seen;

   // Select inputs are only captured after reset release; they must be stable by then
   always_comb
   begin
      nxt_sel_seen = {low_speed_select, echo_clock_enable, latency_select, io_standard_select};
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cal_disable_ff <= 1'b0;
         sel_seen_ff <= 4'h0;
      end
      else
      begin
         cal_disable_ff <= !impedance_match;
         sel_seen_ff <= nxt_sel_seen;
      end
   end

   dpmb_startup u_startup (
      .clk(clk),
      .rst_n(rst_n),
      .cal_disable(cal_disable_ff),
      .ready_ff(ready_int),
      .oper_ff(oper_int)
   );

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ready_n_ff <= 1'b1;
         operational_ff <= 1'b0;
      end
      else
      begin
         ready_n_ff <= !ready_int;
         operational_ff <= oper_int;
      end
   end

endmodule : dpmb_port_ctrl
`default_nettype wire

// ### core/dpmb_startup.sv
// Start-up sequencer: calibration wait and ready indication shared by both ports
`timescale 1ns/1ns
`default_nettype none
module dpmb_startup
   import dpmb_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cal_disable,
   output logic ready_ff,
   output logic oper_ff
);

   dpmb_start_t state_ff;
   dpmb_start_t nxt_state;
   logic [READY_CNT_W-1:0] cnt_ff;
   logic [READY_CNT_W-1:0] nxt_cnt;
   logic nxt_ready;
   logic nxt_oper;
   logic [READY_CNT_W-1:0] limit;

   always_comb
   begin
      // Two flop stages follow this count, so stop early to keep the bound
      limit = cal_disable ? READY_CNT_W'(READY_NOCAL_CYC - 3)
                          : READY_CNT_W'(READY_CAL_CYC - 3);
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_ready = ready_ff;
      nxt_oper = oper_ff;
      case (state_ff)
         ST_RESET:
         begin
            nxt_state = ST_CAL;
            nxt_cnt = READY_CNT_W'(1);
         end
         ST_CAL:
         begin
            nxt_cnt = cnt_ff + READY_CNT_W'(1);
            if (cal_disable && cnt_ff >= READY_CNT_W'(OPER_NOCAL_CYC - 3))
               nxt_oper = 1'b1;
            if (cnt_ff >= limit)
            begin
               nxt_ready = 1'b1;
               nxt_oper = 1'b1;
               nxt_state = ST_READY;
            end
         end
         ST_READY: nxt_state = ST_READY;
         default: nxt_state = ST_RESET;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff <= ST_RESET;
         cnt_ff <= '0;
         ready_ff <= 1'b0;
         oper_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         ready_ff <= nxt_ready;
         oper_ff <= nxt_oper;
      end
   end

endmodule : dpmb_startup
`default_nettype wire

// ### verif/dpmb_host.sv
// Host controller model for one memory port
`timescale 1ns/1ns
`default_nettype none
module dpmb_host
   import dpmb_pkg::*;
(
   input wire logic clk,
   output var dpmb_acc_t acc
);
   initial acc = '0;
   // Released address is inverted so a stale value never looks like a request
   task automatic xfer(input logic ce, input logic wr, input logic [3:0] be,
      input logic [ADDR_W-1:0] addr);
      @(posedge clk);
      acc <= '{ce: ce, rd: !wr, wr: wr, be: be, addr: addr};
      @(posedge clk);
      acc <= '{ce: 1'b0, rd: 1'b0, wr: 1'b0, be: 4'h0, addr: ~addr};
   endtask : xfer
endmodule : dpmb_host
`default_nettype wire

// ### verif/dpmb_port_ctrl_sva.sv
// Pin-level assertions for the port controller
`timescale 1ns/1ns
`default_nettype none
module dpmb_port_ctrl_sva
   import dpmb_pkg::*;
#(
   parameter int AW = ADDR_W
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire dpmb_acc_t acc_left,
   input wire dpmb_acc_t acc_right,
   input wire dpmb_cnt_cmd_t cnt_cmd_left,
   input wire logic impedance_match,
   input wire logic int_left_n_ff,
   input wire logic int_right_n_ff,
   input wire logic busy_n_ff,
   input wire logic counter_wrap_irq_n_ff,
   input wire logic ready_n_ff,
   input wire logic operational_ff,
   input wire logic [AW-1:0] cnt_left,
   input wire logic [AW-1:0] mask_left
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   logic set_r, set_l, clr_r, incr_l;
   logic [10:0] rel_ff, nxt_rel;
   assign set_r = acc_left.ce && acc_left.wr && |acc_left.be && acc_left.addr == 21'h1fffff;
   assign set_l = acc_right.ce && acc_right.wr && |acc_right.be && acc_right.addr == 21'h1ffffe;
   assign clr_r = acc_right.ce && acc_right.rd && |acc_right.be && acc_right.addr == 21'h1fffff;
   // Increment only when no higher-priority command shares the cycle
   assign incr_l = cnt_cmd_left.incr && cnt_cmd_left[AW+4:AW+1] == 4'h0;
   // ----------------------------------------
   // Cycles since reset release, saturating
   // ----------------------------------------
   always_comb
      nxt_rel = (rel_ff == 11'h7ff) ? rel_ff : rel_ff + 11'h1;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n)
         rel_ff <= 11'h0;
      else
         rel_ff <= nxt_rel;
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   property p_set_r;
      set_r |=> !int_right_n_ff;
   endproperty
   a_set_r: assert property (p_set_r) else $error("right flag not set");
   property p_set_l;
      set_l |=> !int_left_n_ff;
   endproperty
   a_set_l: assert property (p_set_l) else $error("left flag not set");
   property p_hold_r;
      !int_right_n_ff && !clr_r |=> !int_right_n_ff;
   endproperty
   a_hold_r: assert property (p_hold_r) else $error("right flag lost");
   property p_clr_r;
      clr_r && !set_r |=> int_right_n_ff;
   endproperty
   a_clr_r: assert property (p_clr_r) else $error("right flag not cleared");
   property p_nobe;
      int_right_n_ff && !set_r |=> $stable(int_right_n_ff);
   endproperty
   a_nobe: assert property (p_nobe) else $error("right flag set without cause");
   property p_rst;
      $rose(rst_n) |-> ready_n_ff && int_left_n_ff && int_right_n_ff && busy_n_ff
         && counter_wrap_irq_n_ff && cnt_left == '0 && mask_left == MASK_RST_VAL;
   endproperty
   a_rst: assert property (p_rst) else $error("reset values wrong");
   property p_step4;
      incr_l && mask_left[4:0] == 5'h1c && cnt_left[4:2] != 3'h7
         |=> cnt_left == $past(cnt_left) + 21'h4;
   endproperty
   a_step4: assert property (p_step4) else $error("step of four wrong");
   property p_ready;
      rel_ff > 11'h3ff |-> !ready_n_ff;
   endproperty
   a_ready: assert property (p_ready) else $error("ready late");
   property p_oper;
      !impedance_match && rel_ff > 11'h4 |-> operational_ff && (rel_ff <= 11'ha0 || !ready_n_ff);
   endproperty
   a_oper: assert property (p_oper) else $error("uncalibrated start late");
   c_set_r: cover property (set_r && int_right_n_ff);
   c_clr_r: cover property (clr_r && !int_right_n_ff);
   c_ready: cover property ($fell(ready_n_ff));
endmodule : dpmb_port_ctrl_sva
bind dpmb_port_ctrl dpmb_port_ctrl_sva #(.AW(AW)) dpmb_port_ctrl_sva_i (.clk, .rst_n,
   .acc_left, .acc_right, .cnt_cmd_left, .impedance_match, .int_left_n_ff, .int_right_n_ff,
   .busy_n_ff, .counter_wrap_irq_n_ff, .ready_n_ff, .operational_ff, .cnt_left, .mask_left);
`default_nettype wire

// ### verif/tb_dpmb_port_ctrl.sv
// Self-checking bench for the mailbox and reset controller
`timescale 1ns/1ns
`default_nettype none
module tb_dpmb_port_ctrl import dpmb_pkg::*;;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic impedance_match = 1'b1;
   logic busy_event = 1'b0;
   logic sel_in = 1'b1;
   logic [ADDR_W-1:0] busy_addr_in = 21'h0abcde;
   dpmb_acc_t acc_left, acc_right;
   dpmb_cnt_cmd_t cnt_cmd_left = '0;
   dpmb_cnt_cmd_t cnt_cmd_right = '0;
   logic int_left_n_ff, int_right_n_ff, busy_n_ff, counter_wrap_irq_n_ff;
   logic ready_n_ff, operational_ff;
   logic [ADDR_W-1:0] busy_addr_ff, cnt_left, mask_left;
   int miscompares = 0;
   int compares = 0;
   always #20 clk = ~clk;
   dpmb_host host_left_i (.clk(clk), .acc(acc_left));
   dpmb_host host_right_i (.clk(clk), .acc(acc_right));
   dpmb_port_ctrl dpmb_port_ctrl_i (.clk, .rst_n, .acc_left, .acc_right, .cnt_cmd_left,
      .cnt_cmd_right, .busy_addr_in, .busy_event, .impedance_match, .low_speed_select(sel_in),
      .echo_clock_enable(sel_in), .latency_select(sel_in), .io_standard_select(sel_in),
      .int_left_n_ff, .int_right_n_ff, .busy_n_ff, .busy_addr_ff, .counter_wrap_irq_n_ff,
      .ready_n_ff, .operational_ff, .cnt_left, .cnt_right(), .mask_left, .mask_right());
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (miscompares == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk_rst;
      chk("int_left", int_left_n_ff, 1);
      chk("int_right", int_right_n_ff, 1);
      chk("busy", busy_n_ff, 1);
      chk("wrap", counter_wrap_irq_n_ff, 1);
      chk("ready", ready_n_ff, 1);
      chk("cnt", cnt_left, 0);
      chk("mask", mask_left, 21'h1fffff);
      chk("busy_addr", busy_addr_ff, 0);
   endtask : chk_rst
   // Limits carry 1 cycle of sampling at the falling edge
   task automatic t_start(input int lim_rdy, input int lim_op);
      int n;
      int op_at;
      op_at = 9999;
      for (n = 1; n < 1100; n++)
      begin
         @(negedge clk);
         if (op_at == 9999 && operational_ff === 1'b1)
            op_at = n;
         if (ready_n_ff === 1'b0)
            break;
      end
      chk("ready time", n <= lim_rdy, 1);
      chk("oper time", op_at <= lim_op, 1);
   endtask : t_start
   task automatic t_mailbox;
      host_left_i.xfer(1'b1, 1'b1, 4'h1, 21'h1fffff);
      @(negedge clk);
      chk("int_right set", int_right_n_ff, 0);
      chk("int_left idle", int_left_n_ff, 1);
      host_left_i.xfer(1'b1, 1'b0, 4'hf, 21'h1fffff);
      host_right_i.xfer(1'b1, 1'b0, 4'h0, 21'h1fffff);
      host_right_i.xfer(1'b0, 1'b0, 4'hf, 21'h1fffff);
      @(negedge clk);
      chk("int_right held", int_right_n_ff, 0);
      host_right_i.xfer(1'b1, 1'b0, 4'h8, 21'h1fffff);
      @(negedge clk);
      chk("int_right clear", int_right_n_ff, 1);
      host_right_i.xfer(1'b1, 1'b1, 4'h2, 21'h1ffffe);
      @(negedge clk);
      chk("int_left set", int_left_n_ff, 0);
      host_left_i.xfer(1'b1, 1'b0, 4'h4, 21'h1ffffe);
      @(negedge clk);
      chk("int_left clear", int_left_n_ff, 1);
   endtask : t_mailbox
   task automatic t_count;
      logic [ADDR_W-1:0] m[4];
      logic [ADDR_W-1:0] e[4];
      m = '{21'h1fffff, 21'h1ffffe, 21'h1ffffc, 21'h003ffc};
      e = '{21'h100006, 21'h100007, 21'h100009, 21'h100009};
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         cnt_cmd_left <= '{mask_load: 1'b1, addr: m[i], default: '0};
         @(posedge clk);
         cnt_cmd_left <= '{cnt_load: 1'b1, addr: 21'h100005, default: '0};
         @(posedge clk);
         cnt_cmd_left <= '{incr: 1'b1, default: '0};
         @(posedge clk);
         cnt_cmd_left <= '0;
         @(negedge clk);
         chk("count", cnt_left, e[i]);
      end
   endtask : t_count
   task automatic t_midrst;
      host_left_i.xfer(1'b1, 1'b1, 4'h1, 21'h1fffff);
      busy_event <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      chk("busy low", busy_n_ff, 0);
      chk("busy addr", busy_addr_ff, 21'h0abcde);
      @(posedge clk);
      rst_n <= 1'b0;
      impedance_match <= 1'b0;
      repeat (3) @(posedge clk);
      chk_rst();
      busy_event <= 1'b0;
      rst_n <= 1'b1;
      t_start(161, 6);
   endtask : t_midrst
   initial
   begin
      repeat (10) @(posedge clk);
      chk_rst();
      rst_n <= 1'b1;
      t_start(1025, 9999);
      t_mailbox();
      t_count();
      t_midrst();
      tally_and_finish();
   end
   initial
   begin
      #(40 * 4000);
      miscompares++;
      tally_and_finish();
   end
endmodule : tb_dpmb_port_ctrl
`default_nettype wire
